/* inc/conv_ctrl_pkg.sv */
`default_nettype none
package conv_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_CONTROL_MAIN = 5'h00;
  localparam logic [4:0] IDX_ACCUMULATION_CONTROL = 5'h01;
  localparam logic [4:0] IDX_REFERENCE_CLOCK_CONTROL = 5'h02;
  localparam logic [4:0] IDX_DELAY_CONTROL = 5'h03;
  localparam logic [4:0] IDX_WINDOW_MODE_CONTROL = 5'h04;
  localparam logic [4:0] IDX_SAMPLE_LENGTH_CONTROL = 5'h05;
  localparam logic [4:0] IDX_INPUT_SELECT = 5'h06;
  localparam logic [4:0] IDX_RESERVED_GAP = 5'h07;
  localparam logic [4:0] IDX_CONVERSION_COMMAND = 5'h08;
  localparam logic [4:0] IDX_EVENT_INPUT_CONTROL = 5'h09;
  localparam logic [4:0] IDX_INTERRUPT_ENABLE = 5'h0A;
  localparam logic [4:0] IDX_INTERRUPT_FLAG_BITS = 5'h0B;
  localparam logic [4:0] IDX_DEBUG_CONTROL = 5'h0C;
  localparam logic [4:0] IDX_SCRATCH_BYTE = 5'h0D;
  localparam logic [4:0] IDX_CONVERSION_RESULT = 5'h10;
  localparam logic [4:0] IDX_WINDOW_LOW_THRESHOLD = 5'h12;
  localparam logic [4:0] IDX_WINDOW_HIGH_THRESHOLD = 5'h14;
  localparam logic [4:0] IDX_DUTY_TRIM = 5'h16;
  localparam logic [4:0] IDX_INTERRUPT_CLEAR = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 0;
  localparam int BIT_CONTINUOUS = 1;
  localparam int BIT_RESOLUTION = 2;
  localparam int BIT_RUN_STANDBY = 7;
  localparam int BIT_START = 0;
  localparam int BIT_RESULT_READY = 0;
  localparam int BIT_WINDOW_MATCH = 1;
  localparam logic [7:0] MASK_CONTROL_MAIN = 8'h87;
  localparam logic [7:0] MASK_ACCUMULATION = 8'h07;
  localparam logic [7:0] MASK_REFERENCE_CLOCK = 8'h77;
  localparam logic [7:0] MASK_SAMPLE_LENGTH = 8'h1F;
  localparam logic [7:0] MASK_INPUT_SELECT = 8'h1F;
  localparam logic [7:0] MASK_SINGLE_BIT = 8'h01;
  localparam logic [7:0] MASK_INTERRUPT = 8'h03;
  localparam logic [7:0] MASK_WINDOW_MODE = 8'h07;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int CONV_ADC_CYCLES = 13;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_STORE = 2'b11
  } conv_state_e;

endpackage
`default_nettype wire

/* rtl/conv_ctrl.sv */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_ADC_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [9:0] analog_sample_i,
  input wire logic standby_i,
  input wire logic start_event_i,
  output logic converter_enable_o,
  output logic convert_active_o,
  output logic [1:0] reference_select_o,
  output logic sample_capacitance_select_o,
  output logic [4:0] input_select_o,
  output logic result_ready_event_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [4:0] idx;
  logic addr_ok;
  logic wr_en;
  logic setup;

  assign idx = paddr_i[6:2];
  assign addr_ok = (paddr_i[7] == 1'b0) && (paddr_i[1:0] == 2'b00);
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i && addr_ok && pstrb_i[0];
  // Every access completes in its first access cycle
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = 1'b0;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] control_main;
  logic [7:0] accumulation_control;
  logic [7:0] reference_clock_control;
  logic [7:0] delay_control;
  logic [7:0] window_mode_control;
  logic [7:0] sample_length_control;
  logic [7:0] input_select;
  logic [7:0] event_input_control;
  logic [7:0] interrupt_enable;
  logic [7:0] debug_control;
  logic [7:0] scratch_byte;
  logic [15:0] window_low_threshold;
  logic [15:0] window_high_threshold;
  logic [7:0] duty_trim;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      control_main <= RESET_BYTE;
      accumulation_control <= RESET_BYTE;
      reference_clock_control <= RESET_BYTE;
      delay_control <= RESET_BYTE;
      window_mode_control <= RESET_BYTE;
      sample_length_control <= RESET_BYTE;
      input_select <= RESET_BYTE;
      event_input_control <= RESET_BYTE;
      interrupt_enable <= RESET_BYTE;
      debug_control <= RESET_BYTE;
      scratch_byte <= RESET_BYTE;
      duty_trim <= RESET_BYTE;
    end else if (wr_en) begin
      case (idx)
        IDX_CONTROL_MAIN: begin
          control_main <= pwdata_i[7:0] & MASK_CONTROL_MAIN;
        end
        IDX_ACCUMULATION_CONTROL: begin
          accumulation_control <= pwdata_i[7:0] & MASK_ACCUMULATION;
        end
        IDX_REFERENCE_CLOCK_CONTROL: begin
          reference_clock_control <= pwdata_i[7:0] & MASK_REFERENCE_CLOCK;
        end
        IDX_DELAY_CONTROL: begin
          delay_control <= pwdata_i[7:0];
        end
        IDX_WINDOW_MODE_CONTROL: begin
          window_mode_control <= pwdata_i[7:0] & MASK_WINDOW_MODE;
        end
        IDX_SAMPLE_LENGTH_CONTROL: begin
          sample_length_control <= pwdata_i[7:0] & MASK_SAMPLE_LENGTH;
        end
        IDX_INPUT_SELECT: begin
          input_select <= pwdata_i[7:0] & MASK_INPUT_SELECT;
        end
        IDX_EVENT_INPUT_CONTROL: begin
          event_input_control <= pwdata_i[7:0] & MASK_SINGLE_BIT;
        end
        IDX_INTERRUPT_ENABLE: begin
          interrupt_enable <= pwdata_i[7:0] & MASK_INTERRUPT;
        end
        IDX_DEBUG_CONTROL: begin
          debug_control <= pwdata_i[7:0] & MASK_SINGLE_BIT;
        end
        IDX_SCRATCH_BYTE: begin
          scratch_byte <= pwdata_i[7:0];
        end
        IDX_DUTY_TRIM: begin
          duty_trim <= pwdata_i[7:0] & MASK_SINGLE_BIT;
        end
        default: begin
        end
      endcase
    end
  end

  // Thresholds take each byte lane on its own strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      window_low_threshold <= RESET_WORD;
      window_high_threshold <= RESET_WORD;
    end else if (psel_i && penable_i && pwrite_i && addr_ok) begin
      if (idx == IDX_WINDOW_LOW_THRESHOLD) begin
        if (pstrb_i[0]) begin
          window_low_threshold[7:0] <= pwdata_i[7:0];
        end
        if (pstrb_i[1]) begin
          window_low_threshold[15:8] <= pwdata_i[15:8];
        end
      end
      if (idx == IDX_WINDOW_HIGH_THRESHOLD) begin
        if (pstrb_i[0]) begin
          window_high_threshold[7:0] <= pwdata_i[7:0];
        end
        if (pstrb_i[1]) begin
          window_high_threshold[15:8] <= pwdata_i[15:8];
        end
      end
    end
  end

  logic enable;
  logic continuous_conversion;
  logic resolution_select;
  logic keep_running_in_standby;
  logic halt;

  assign enable = control_main[BIT_ENABLE];
  assign continuous_conversion = control_main[BIT_CONTINUOUS];
  assign resolution_select = control_main[BIT_RESOLUTION];
  assign keep_running_in_standby = control_main[BIT_RUN_STANDBY];
  // Standby freezes the converter unless told to keep running
  assign halt = standby_i && !keep_running_in_standby;

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_cnt;
  logic [7:0] div_last;
  logic tick;

  always_comb begin
    div_last = 8'((9'h002 << reference_clock_control[2:0]) - 9'h001);
  end
  assign tick = (div_cnt == div_last);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
    end else if (!enable || tick) begin
      div_cnt <= 8'h00;
    end else if (!halt) begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Start command and event trigger
  // ----------------------------------------------------------------
  conv_state_e state;
  logic start_pending;
  logic event_prev;
  logic event_rise;
  logic start_write;
  logic take_start;

  assign event_rise = start_event_i && !event_prev && event_input_control[0];
  assign start_write = wr_en && (idx == IDX_CONVERSION_COMMAND) &&
                       pwdata_i[BIT_START];
  assign take_start = (state == ST_IDLE) && start_pending && enable && !halt;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      event_prev <= 1'b0;
    end else begin
      event_prev <= start_event_i;
    end
  end

  // A new start in the cycle that consumes the old one is kept
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_pending <= 1'b0;
    end else if (enable && (start_write || event_rise)) begin
      start_pending <= 1'b1;
    end else if (take_start || !enable) begin
      start_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
  logic [7:0] adc_cnt;
  logic [6:0] sample_cnt;
  logic [6:0] acc_target;
  logic [6:0] next_sample_cnt;
  logic [15:0] sample_val;
  logic [15:0] acc_sum;
  logic [15:0] conversion_result;
  logic conv_end;

  always_comb begin
    // Reserved code 7 falls back to a single sample
    if (accumulation_control[2:0] == 3'h7) begin
      acc_target = 7'h01;
    end else begin
      acc_target = 7'(8'h01 << accumulation_control[2:0]);
    end
  end

  always_comb begin
    if (resolution_select) begin
      sample_val = {8'h00, analog_sample_i[9:2]};
    end else begin
      sample_val = {6'h00, analog_sample_i};
    end
  end

  assign next_sample_cnt = sample_cnt + 7'h01;
  // Enable in the end term keeps a sample from landing as the block shuts off
  assign conv_end = (state == ST_CONVERT) && enable && !halt && tick &&
                    (adc_cnt == CONV_LAST);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      adc_cnt <= 8'h00;
      sample_cnt <= 7'h00;
      acc_sum <= RESET_WORD;
    end else if (!enable) begin
      state <= ST_IDLE;
      adc_cnt <= 8'h00;
      sample_cnt <= 7'h00;
      acc_sum <= RESET_WORD;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_start) begin
            state <= ST_CONVERT;
            adc_cnt <= 8'h00;
            sample_cnt <= 7'h00;
            acc_sum <= RESET_WORD;
          end
        end
        ST_CONVERT: begin
          if (conv_end) begin
            adc_cnt <= 8'h00;
            acc_sum <= acc_sum + sample_val;
            sample_cnt <= next_sample_cnt;
            if (next_sample_cnt == acc_target) begin
              state <= ST_STORE;
            end
          end else if (!halt && tick) begin
            adc_cnt <= adc_cnt + 8'h01;
          end
        end
        ST_STORE: begin
          adc_cnt <= 8'h00;
          sample_cnt <= 7'h00;
          acc_sum <= RESET_WORD;
          if (continuous_conversion) begin
            state <= ST_CONVERT;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result <= RESET_WORD;
    end else if (state == ST_STORE) begin
      conversion_result <= acc_sum;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result_ready_event_o <= 1'b0;
    end else begin
      result_ready_event_o <= (state == ST_STORE);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [1:0] interrupt_flag_bits;
  logic clear_write;

  assign clear_write = wr_en && (idx == IDX_INTERRUPT_CLEAR);

  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_flag_bits <= 2'b00;
    end else if (state == ST_STORE) begin
      interrupt_flag_bits[BIT_RESULT_READY] <= 1'b1;
    end else if (clear_write && pwdata_i[BIT_RESULT_READY]) begin
      interrupt_flag_bits[BIT_RESULT_READY] <= 1'b0;
    end
  end

  assign irq_o = |(interrupt_flag_bits & interrupt_enable[1:0]);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic start_status;

  assign start_status = start_pending || (state != ST_IDLE);

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_ok) begin
      case (idx)
        IDX_CONTROL_MAIN: next_prdata[7:0] = control_main;
        IDX_ACCUMULATION_CONTROL: next_prdata[7:0] = accumulation_control;
        IDX_REFERENCE_CLOCK_CONTROL: begin
          next_prdata[7:0] = reference_clock_control & MASK_REFERENCE_CLOCK;
        end
        IDX_DELAY_CONTROL: next_prdata[7:0] = delay_control;
        IDX_WINDOW_MODE_CONTROL: next_prdata[7:0] = window_mode_control;
        IDX_SAMPLE_LENGTH_CONTROL: next_prdata[7:0] = sample_length_control;
        IDX_INPUT_SELECT: next_prdata[7:0] = input_select;
        IDX_CONVERSION_COMMAND: next_prdata[BIT_START] = start_status;
        IDX_EVENT_INPUT_CONTROL: next_prdata[7:0] = event_input_control;
        IDX_INTERRUPT_ENABLE: next_prdata[7:0] = interrupt_enable;
        IDX_INTERRUPT_FLAG_BITS: next_prdata[1:0] = interrupt_flag_bits;
        IDX_DEBUG_CONTROL: next_prdata[7:0] = debug_control;
        IDX_SCRATCH_BYTE: next_prdata[7:0] = scratch_byte;
        IDX_CONVERSION_RESULT: next_prdata[15:0] = conversion_result;
        IDX_WINDOW_LOW_THRESHOLD: next_prdata[15:0] = window_low_threshold;
        IDX_WINDOW_HIGH_THRESHOLD: next_prdata[15:0] = window_high_threshold;
        IDX_DUTY_TRIM: next_prdata[7:0] = duty_trim;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data is caught in the setup cycle so it comes from a flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      prdata_o <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------
  assign converter_enable_o = enable;
  assign convert_active_o = (state == ST_CONVERT);
  assign reference_select_o = reference_clock_control[5:4];
  assign sample_capacitance_select_o = reference_clock_control[6];
  assign input_select_o = input_select[4:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start_seen;
    (state == ST_IDLE) && start_pending && enable && !halt;
  endsequence

  sequence s_store_continuous;
    (state == ST_STORE) && continuous_conversion && enable;
  endsequence

  AST_DISABLED_IDLE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !enable |=> (state == ST_IDLE) && !start_status)
    else $error("converter active while disabled");

  AST_STANDBY_FREEZE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (halt && enable && !tick) |=> $stable(div_cnt))
    else $error("divider moved during standby freeze");

  AST_FULL_RANGE: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state == ST_CONVERT) && conv_end && !resolution_select &&
    (acc_target == 7'h01) |=> acc_sum == {6'h00, $past(analog_sample_i)})
    else $error("ten-bit sample not kept whole");

  AST_EIGHT_BIT: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    conv_end && resolution_select && (acc_target == 7'h01) |=>
    acc_sum == {8'h00, $past(analog_sample_i[9:2])})
    else $error("eight-bit sample not truncated");

  AST_WAIT_FOR_START: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state == ST_IDLE) && !start_pending |=> (state != ST_CONVERT))
    else $error("conversion began without start");

  AST_CONTINUOUS_RESTART: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    s_store_continuous |=> (state == ST_CONVERT) &&
    interrupt_flag_bits[BIT_RESULT_READY] ##1 result_ready_event_o == 1'b0)
    else $error("continuous restart or flag missing");

  AST_SAMPLE_COUNT: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (state == ST_STORE) |-> (sample_cnt == acc_target))
    else $error("wrong number of samples summed");

  AST_REF_RESERVED_ZERO: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (reference_clock_control & 8'h88) == 8'h00)
    else $error("reserved reference bits set");

  AST_DIVIDER_SPACING: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    tick && enable && (reference_clock_control[2:0] == 3'h1) |=>
    !tick [*3])
    else $error("divide-by-four spacing broken");

  AST_START_TAKEN: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    s_start_seen |=> (state == ST_CONVERT) && start_status)
    else $error("start not taken");

  AST_RESERVED_READ: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    setup && (idx == IDX_RESERVED_GAP) |=> (prdata_o == 32'h0000_0000))
    else $error("reserved location read nonzero");

endmodule // conv_ctrl
`default_nettype wire

/* testbench/conv_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_bench
  import conv_ctrl_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, standby = 1'b0, evt = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic [3:0] pstrb = 4'hF;
  logic [9:0] sample = 10'h2AB;
  logic pready, pslverr, en, active, cap, rdy, irq;
  logic [1:0] refs;
  logic [4:0] insel;
  int errors = 0, n_compared = 0;
  int waited = 0;
  localparam int CONV_TICKS = 2;

  always #5 clk = ~clk;

  conv_ctrl #(.CONV_CYCLES(CONV_TICKS)) uut (.clk_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .analog_sample_i(sample),
    .standby_i(standby), .start_event_i(evt), .converter_enable_o(en),
    .convert_active_o(active), .reference_select_o(refs),
    .sample_capacitance_select_o(cap), .input_select_o(insel),
    .result_ready_event_o(rdy), .irq_o(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Master holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [4:0] idx,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      $display("[FAIL] %0t no pready", $time);
      conclude;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(q, e, "read");
  endtask

  task automatic wait_rdy;
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    waited = i;
    if (i == 400) begin
      errors++;
      $display("[FAIL] %0t no result", $time);
      conclude;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(5'h00, 32'h0);
    rd(5'h01, 32'h0);
    rd(5'h02, 32'h0);
    apb(1'b1, 5'h00, 32'hFF);
    rd(5'h00, 32'h87);
    chk(32'(en), 32'h1, "enable out");
    apb(1'b1, 5'h02, 32'hFF);
    rd(5'h02, 32'h77);
    chk(32'(refs), 32'h3, "ref out");
    chk(32'(cap), 32'h1, "cap out");
    apb(1'b1, 5'h01, 32'hFF);
    rd(5'h01, 32'h07);
    apb(1'b1, 5'h07, 32'hFF);
    rd(5'h07, 32'h0);
    apb(1'b1, 5'h0E, 32'hFF);
    rd(5'h0E, 32'h0);
    apb(1'b1, 5'h06, 32'hFF);
    rd(5'h06, 32'h1F);
    chk(32'(insel), 32'h1F, "input out");
    apb(1'b1, 5'h12, 32'hFFFF_1234);
    rd(5'h12, 32'h1234);
    apb(1'b1, 5'h14, 32'h0000_ABCD);
    rd(5'h14, 32'hABCD);
    apb(1'b1, 5'h0C, 32'hFF);
    rd(5'h0C, 32'h01);
    apb(1'b1, 5'h0D, 32'hA5);
    rd(5'h0D, 32'hA5);
    apb(1'b1, 5'h16, 32'hFF);
    rd(5'h16, 32'h01);
    apb(1'b1, 5'h10, 32'hFF);
    rd(5'h10, 32'h0);
    chk(32'(pslverr), 32'h0, "slverr");
    apb(1'b1, 5'h02, 32'h0);
    apb(1'b1, 5'h00, 32'h0);
    @(posedge clk);
    chk(32'(en), 32'h0, "disabled");
    apb(1'b1, 5'h01, 32'h0);
  endtask

  task automatic t_single;
    apb(1'b1, 5'h00, 32'h01);
    apb(1'b1, 5'h0A, 32'h01);
    apb(1'b1, 5'h08, 32'h01);
    rd(5'h08, 32'h1);
    wait_rdy;
    rd(5'h10, 32'h2AB);
    rd(5'h08, 32'h0);
    rd(5'h0B, 32'h1);
    chk(32'(irq), 32'h1, "irq set");
    apb(1'b1, 5'h0A, 32'h0);
    @(posedge clk);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b1, 5'h0A, 32'h1);
    apb(1'b1, 5'h18, 32'h1);
    rd(5'h0B, 32'h0);
    chk(32'(irq), 32'h0, "irq cleared");
  endtask

  // Count codes 0 to 6 each give 2^code summed samples as one result
  task automatic t_accum;
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, 5'h01, 32'(c));
      apb(1'b1, 5'h08, 32'h1);
      wait_rdy;
      rd(5'h10, 32'h2AB << c);
      @(posedge clk);
      chk(32'(active), 32'h0, "one result");
    end
    apb(1'b1, 5'h00, 32'h05);
    apb(1'b1, 5'h01, 32'h02);
    apb(1'b1, 5'h08, 32'h1);
    wait_rdy;
    rd(5'h10, 32'h2A8);
    apb(1'b1, 5'h01, 32'h0);
    apb(1'b1, 5'h08, 32'h1);
    wait_rdy;
    rd(5'h10, 32'h0AA);
  endtask

  // Divide by four: each sample spans four-cycle ticks, phase unknown
  task automatic t_divider;
    logic in_range;
    apb(1'b1, 5'h02, 32'h01);
    apb(1'b1, 5'h08, 32'h1);
    wait_rdy;
    in_range = (waited >= 4 * CONV_TICKS - 1) &&
               (waited <= 4 * CONV_TICKS + 2);
    chk(32'(in_range), 32'h1, "divide by four");
    apb(1'b1, 5'h02, 32'h0);
  endtask

  task automatic t_free;
    apb(1'b1, 5'h00, 32'h03);
    repeat (20) @(posedge clk);
    chk(32'(active), 32'h0, "waits start");
    apb(1'b1, 5'h08, 32'h1);
    wait_rdy;
    wait_rdy;
    chk(32'(active), 32'h1, "restart");
    apb(1'b1, 5'h00, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(active), 32'h0, "abort");
    rd(5'h08, 32'h0);
  endtask

  task automatic t_standby;
    standby <= 1'b1;
    apb(1'b1, 5'h00, 32'h01);
    apb(1'b1, 5'h08, 32'h1);
    repeat (30) @(posedge clk);
    chk(32'(active), 32'h0, "halted");
    apb(1'b1, 5'h00, 32'h81);
    wait_rdy;
    standby <= 1'b0;
    apb(1'b1, 5'h09, 32'h1);
    apb(1'b1, 5'h00, 32'h01);
    evt <= 1'b1;
    wait_rdy;
    evt <= 1'b0;
    rd(5'h10, 32'h2AB);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_single;
    t_divider;
    t_accum;
    t_free;
    t_standby;
    conclude;
  end
endmodule // conv_ctrl_bench
`default_nettype wire
